// file: design/sgp_pkg.sv
/*
  shared constants and carriers of the subsystem general-purpose i/o port.
  assumes a single core clock and a synchronous active-low core reset.
*/
package sgp_pkg;

  localparam int PIN_COUNT = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // memory-mapped location of the pin_control_data register
  localparam logic [ADDR_W-1:0] PIN_CTRL_ADDR = 8'h3C;
  localparam logic [DATA_W-1:0] PIN_CTRL_RESET = 16'h0000;
  // bits 14 and 5..4 are reserved
  localparam logic [DATA_W-1:0] PIN_CTRL_MASK = 16'hBFCF;

  // field positions
  localparam int TIMER_SEL_BIT = 15;
  localparam int BRANCH_SEL_BIT = 13;
  localparam int FLAG_SEL_BIT = 12;
  localparam int DIR_LSB = 8;
  localparam int CLK_SEL_LSB = 6;
  localparam int VALUE_LSB = 0;

  // pins that carry an alternate function
  localparam int FLAG_PIN = 0;
  localparam int BRANCH_PIN = 1;
  localparam int WATCHDOG_PIN = 2;
  localparam int TIMER_PIN = 3;
  // data bits where the flag and branch values read back
  localparam int FLAG_READ_BIT = 1;
  localparam int BRANCH_READ_BIT = 0;

  // branch-control level presented while the branch input is deselected
  localparam logic BRANCH_IDLE = 1'b1;

  typedef enum logic [1:0] {
    SGP_CLK_A,
    SGP_CLK_B,
    SGP_CLK_C,
    SGP_CLK_D
  } sgp_clk_sel_e;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sgp_req_s;

  typedef struct packed {
    logic [PIN_COUNT-1:0] level;
    logic [PIN_COUNT-1:0] oe;
  } sgp_pins_s;

endpackage : sgp_pkg

// file: design/sgp_port.sv
/*
  subsystem general-purpose i/o port: one control/data register on the core's
  data bus, four three-state pins with timer, watchdog, flag and branch overrides,
  and the shared clock-out selection.
  assumes timer, watchdog, flag and bus signals come from core-clock logic;
  pin inputs are asynchronous and pass the synchroniser first.
*/
// Functional notes
// R01: bits 11..8 set each pin's direction, 0 input and 1 output.
// R02: bits 3..0 give the driven level of output pins and read the pin level of input pins.
// R03: bit 15 drives the timer output on pin 3 over its direction and reads it in bit 3.
// R04: bit 13 makes pin 1 the branch-control input over its direction, readable in bit 0.
// R05: bit 12 drives the external flag on pin 0 over its direction, readable in bit 1.
// R06: bits 14 and 5..4 read zero and ignore writes.
// R07: bits 7..6 pick subsystem a, b, c or d for the shared clock output pin.
// R08: core reset clears the whole register so all pins are inputs without overrides; after reset pin 2 drives the watchdog output while it is selected.
// R09: the register sits at data address 3Ch.
// R10: each pin has its own output enable, high only when it drives.
// R11: the watchdog pin enable chooses between watchdog output and plain i/o on pin 2.
// R12: all non-reserved bits can be written and read back; bits 3..0 read back as R02 to R05 describe, not always as written.
// R13: with the watchdog selected, pin 2 drives the watchdog output whatever its direction.
`timescale 1ns/1ps
module sgp_port (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire sgp_pkg::sgp_req_s req_i,
  output logic [sgp_pkg::DATA_W-1:0] rdata_o,
  input wire logic timer_out_i,
  input wire logic watchdog_out_i,
  input wire logic watchdog_pin_enable_i,
  input wire logic flag_out_i,
  input wire logic [sgp_pkg::PIN_COUNT-1:0] pin_i,
  output sgp_pkg::sgp_pins_s pins_o,
  output logic branch_level_o,
  output logic [1:0] clock_out_select_o
);

  ////////////////////////////////////////////////////////////////////////////
  // register and decode

  localparam int N = sgp_pkg::PIN_COUNT;

  logic [sgp_pkg::DATA_W-1:0] ctrl_reg;
  logic [sgp_pkg::DATA_W-1:0] ctrl_next;
  logic [sgp_pkg::DATA_W-1:0] rdata_reg;
  logic [sgp_pkg::DATA_W-1:0] rdata_next;
  sgp_pkg::sgp_pins_s pins_reg;
  sgp_pkg::sgp_pins_s pins_next;
  logic branch_reg;
  logic branch_next;
  logic [1:0] clk_sel_reg;
  logic [N-1:0] pin_sync;
  logic [N-1:0] pin_direction;
  logic [N-1:0] pin_value;
  logic [N-1:0] alt_level;
  logic [N-1:0] forced_out;
  logic [N-1:0] read_value;
  logic timer_pin_select;
  logic branch_input_select;
  logic flag_output_select;
  logic hit;
  logic wr_hit;
  logic rd_hit;

  // pin i/o override: 1 forces the pin to drive its alternate source
  function automatic logic [N-1:0] forced_drive(input logic [sgp_pkg::DATA_W-1:0] c,
                                                input logic wd_en);
    logic [N-1:0] f;
    f = '0;
    f[sgp_pkg::TIMER_PIN] = c[sgp_pkg::TIMER_SEL_BIT];
    f[sgp_pkg::WATCHDOG_PIN] = wd_en;
    f[sgp_pkg::FLAG_PIN] = c[sgp_pkg::FLAG_SEL_BIT];
    return f;
  endfunction : forced_drive

  sgp_sync #(
    .WIDTH(N)
  ) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i(pin_i),
    .sync_o(pin_sync)
  );

  assign hit = (req_i.addr == sgp_pkg::PIN_CTRL_ADDR); // see R09
  assign wr_hit = req_i.wr && hit;
  assign rd_hit = req_i.rd && hit;

  assign timer_pin_select = ctrl_reg[sgp_pkg::TIMER_SEL_BIT];
  assign branch_input_select = ctrl_reg[sgp_pkg::BRANCH_SEL_BIT];
  assign flag_output_select = ctrl_reg[sgp_pkg::FLAG_SEL_BIT];
  assign pin_direction = ctrl_reg[sgp_pkg::DIR_LSB +: N];
  assign pin_value = ctrl_reg[sgp_pkg::VALUE_LSB +: N];

  // reserved bits are masked off on the way in so they can never read back
  assign ctrl_next = wr_hit ? (req_i.wdata & sgp_pkg::PIN_CTRL_MASK) : ctrl_reg; // see R06 R12

  ////////////////////////////////////////////////////////////////////////////
  // pin drive

  assign forced_out = forced_drive(ctrl_reg, watchdog_pin_enable_i); // see R03 R05 R11 R13

  always_comb begin
    alt_level = pin_value;
    alt_level[sgp_pkg::TIMER_PIN] = timer_out_i;
    alt_level[sgp_pkg::WATCHDOG_PIN] = watchdog_out_i;
    alt_level[sgp_pkg::FLAG_PIN] = flag_out_i;
  end

  for (genvar k = 0; k < N; k++) begin : g_pin
    logic is_out;
    // branch select turns pin 1 into an input even when its direction is output
    assign is_out = forced_out[k] ||
                    (pin_direction[k] &&
                     !(k == sgp_pkg::BRANCH_PIN && branch_input_select)); // see R01 R04
    assign pins_next.oe[k] = is_out; // see R10
    assign pins_next.level[k] = is_out ? (forced_out[k] ? alt_level[k] : pin_value[k])
                                       : 1'b0; // see R02
    // forced pins read their alternate source, other output pins their stored level, input pins their sampled level
    assign read_value[k] = forced_out[k] ? alt_level[k]
                           : (pins_next.oe[k] ? pin_value[k] : pin_sync[k]); // see R02 R03
  end

  assign branch_next = branch_input_select ? pin_sync[sgp_pkg::BRANCH_PIN]
                                           : sgp_pkg::BRANCH_IDLE; // see R04

  ////////////////////////////////////////////////////////////////////////////
  // read data

  always_comb begin
    rdata_next = '0;
    if (rd_hit) begin
      rdata_next = ctrl_reg; // see R12
      rdata_next[sgp_pkg::VALUE_LSB +: N] = read_value;
      if (branch_input_select) begin
        rdata_next[sgp_pkg::BRANCH_READ_BIT] = pin_sync[sgp_pkg::BRANCH_PIN]; // see R04
      end
      if (flag_output_select) begin
        rdata_next[sgp_pkg::FLAG_READ_BIT] = flag_out_i; // see R05
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= sgp_pkg::PIN_CTRL_RESET; // see R08
      rdata_reg <= '0;
      pins_reg <= '0;
      branch_reg <= sgp_pkg::BRANCH_IDLE;
      clk_sel_reg <= sgp_pkg::SGP_CLK_A;
    end else begin
      ctrl_reg <= ctrl_next;
      rdata_reg <= rdata_next;
      pins_reg <= pins_next;
      branch_reg <= branch_next;
      clk_sel_reg <= ctrl_reg[sgp_pkg::CLK_SEL_LSB +: 2]; // see R07
    end
  end

  assign rdata_o = rdata_reg;
  assign pins_o = pins_reg;
  assign branch_level_o = branch_reg;
  assign clock_out_select_o = clk_sel_reg;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  reset_clear_a: assert property ( // see R08
    @(posedge clk_i) $rose(rst_n_i) |-> (ctrl_reg == '0) && (pins_o.oe == '0))
    else $error("port register not cleared by reset");

  write_store_a: assert property ( // see R12
    @(posedge clk_i) disable iff (!rst_n_i)
    wr_hit |=> ctrl_reg == ($past(req_i.wdata) & sgp_pkg::PIN_CTRL_MASK))
    else $error("write did not store non-reserved bits");

  reserved_zero_a: assert property ( // see R06
    @(posedge clk_i) disable iff (!rst_n_i)
    (rdata_o[14] == 1'b0) && (rdata_o[5:4] == 2'b00) && !ctrl_reg[14])
    else $error("reserved bit not zero");

  unmapped_read_a: assert property ( // see R09
    @(posedge clk_i) disable iff (!rst_n_i)
    req_i.rd && !hit |=> rdata_o == '0)
    else $error("read away from 3Ch returned data");

  dir_enable_a: assert property ( // see R01 R10
    @(posedge clk_i) disable iff (!rst_n_i)
    !watchdog_pin_enable_i |=> pins_o.oe[2] == $past(ctrl_reg[sgp_pkg::DIR_LSB + 2]))
    else $error("pin 2 enable does not follow its direction");

  timer_drive_a: assert property ( // see R03
    @(posedge clk_i) disable iff (!rst_n_i)
    timer_pin_select |=> pins_o.oe[3] && (pins_o.level[3] == $past(timer_out_i)))
    else $error("timer output not driven on pin 3");

  flag_drive_a: assert property ( // see R05
    @(posedge clk_i) disable iff (!rst_n_i)
    flag_output_select && rd_hit |=>
      pins_o.oe[0] && (pins_o.level[0] == $past(flag_out_i)) && (rdata_o[1] == pins_o.level[0]))
    else $error("flag output not driven or read back");

  branch_input_a: assert property ( // see R04
    @(posedge clk_i) disable iff (!rst_n_i)
    branch_input_select |=> !pins_o.oe[1] && (branch_level_o == $past(pin_sync[1])))
    else $error("branch input not taken from pin 1");

  watchdog_drive_a: assert property ( // see R11 R13
    @(posedge clk_i) disable iff (!rst_n_i)
    watchdog_pin_enable_i |=> pins_o.oe[2] && (pins_o.level[2] == $past(watchdog_out_i)))
    else $error("watchdog output not driven on pin 2");

  input_read_a: assert property ( // see R02
    @(posedge clk_i) disable iff (!rst_n_i)
    rd_hit && !ctrl_reg[sgp_pkg::DIR_LSB + 3] && !timer_pin_select |=>
      rdata_o[3] == $past(pin_sync[3]))
    else $error("input pin level not read back");

  clock_select_a: assert property ( // see R07
    @(posedge clk_i) disable iff (!rst_n_i)
    wr_hit ##1 !wr_hit |=> clock_out_select_o == $past(req_i.wdata[7:6], 2))
    else $error("clock output select does not follow bits 7..6");

endmodule : sgp_port

// file: design/sgp_sync.sv
/*
  two-flop synchroniser for a group of pin inputs.
  assumes inputs are asynchronous to clk_i; reset is synchronous, active low.
*/
`timescale 1ns/1ps
module sgp_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  // stage1 feeds stage2 only, never any other logic
  for (genvar k = 0; k < WIDTH; k++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        stage1_reg[k] <= 1'b0;
        stage2_reg[k] <= 1'b0;
      end else begin
        stage1_reg[k] <= async_i[k];
        stage2_reg[k] <= stage1_reg[k];
      end
    end
  end

  assign sync_o = stage2_reg;

endmodule : sgp_sync

// file: testbench/sgp_board.sv
/*
  board model for the port's pins: devices that drive each pin while the
  port leaves it undriven.
  assumes the pin wire carries the port's level whenever its enable is high.
*/
`timescale 1ns/1ps
module sgp_board (
  input wire sgp_pkg::sgp_pins_s pins_i,
  input wire logic [3:0] board_i,
  output logic [3:0] pin_o
);
  // board drivers sit behind series resistors, so the port wins while it drives
  assign pin_o = (pins_i.oe & pins_i.level) | (~pins_i.oe & board_i);
endmodule : sgp_board

// file: testbench/sgp_port_test.sv
/*
  self-checking bench of the subsystem i/o port with random register and pin traffic.
  assumes the board model on the pins and a 20 MHz core clock.
*/
`timescale 1ns/1ps
module sgp_port_test;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  sgp_pkg::sgp_req_s req_i = '0;
  logic timer_out_i = 1'b0;
  logic watchdog_out_i = 1'b0;
  logic watchdog_pin_enable_i = 1'b0;
  logic flag_out_i = 1'b0;
  logic [3:0] brd = 4'h0;
  logic [3:0] pin_i;
  logic [15:0] rdata_o;
  sgp_pkg::sgp_pins_s pins_o;
  logic branch_level_o;
  logic [1:0] clock_out_select_o;
  logic [15:0] w = 16'h0000;
  int n_errors = 0;
  int tests_run = 0;

  always #25 clk_i = ~clk_i;

  sgp_port u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req_i), .rdata_o(rdata_o),
    .timer_out_i(timer_out_i), .watchdog_out_i(watchdog_out_i),
    .watchdog_pin_enable_i(watchdog_pin_enable_i), .flag_out_i(flag_out_i),
    .pin_i(pin_i), .pins_o(pins_o), .branch_level_o(branch_level_o),
    .clock_out_select_o(clock_out_select_o));
  sgp_board u_board (.pins_i(pins_o), .board_i(brd), .pin_o(pin_i));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [3:0] forced();
    return {w[15], watchdog_pin_enable_i, 1'b0, w[12]};
  endfunction : forced

  function automatic logic [7:0] exp_pins();
    logic [3:0] oe;
    logic [3:0] lv;
    oe = forced() | (w[11:8] & {2'b11, ~w[13], 1'b1});
    lv = oe & ((forced() & {timer_out_i, watchdog_out_i, 1'b0, flag_out_i}) | (~forced() & w[3:0]));
    return {lv, oe};
  endfunction : exp_pins

  function automatic logic [15:0] exp_rd();
    logic [7:0] p;
    logic [3:0] d;
    p = exp_pins();
    d = (p[3:0] & p[7:4]) | (~p[3:0] & brd);
    if (w[13]) d[0] = brd[1];
    if (w[12]) d[1] = flag_out_i;
    return {w[15:6], 2'b00, d};
  endfunction : exp_rd

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one access then an idle cycle, so the strobe is never raised in the edge that drops it
  task automatic access(input logic rd, input logic [7:0] a, input logic [15:0] d,
                        output logic [15:0] q);
    // packed order of the request carrier is rd, wr, addr, wdata
    req_i = {rd, !rd, a, d};
    if (!rd && a == sgp_pkg::PIN_CTRL_ADDR) w = d & sgp_pkg::PIN_CTRL_MASK;
    @(posedge clk_i);
    #1 q = rdata_o;
    req_i = '0;
    @(posedge clk_i);
    #1;
  endtask : access

  // pins settle one cycle after a write and the synchroniser takes two more
  task automatic check_all();
    logic [15:0] q;
    repeat (5) @(posedge clk_i);
    #1;
    access(1'b1, sgp_pkg::PIN_CTRL_ADDR, 16'h0000, q);
    check(q, exp_rd());
    check({8'h00, pins_o}, {8'h00, exp_pins()});
    check({14'h0000, clock_out_select_o}, {14'h0000, w[7:6]});
    check({15'h0000, branch_level_o}, {15'h0000, w[13] ? brd[1] : 1'b1});
  endtask : check_all

  task automatic do_reset();
    rst_n_i = 1'b0;
    repeat (6) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    w = 16'h0000;
  endtask : do_reset

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] q;
    logic [15:0] d;
    void'($urandom(16376));
    do_reset();
    check_all();
    $display("test reset done");
    for (int i = 0; i < 40; i++) begin
      {timer_out_i, watchdog_out_i, watchdog_pin_enable_i, flag_out_i, brd} = 8'($urandom);
      d = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h2F0F : 16'($urandom);
      access(1'b0, sgp_pkg::PIN_CTRL_ADDR, d, q);
      check_all();
    end
    $display("test random traffic done");
    access(1'b0, 8'h3D, 16'hFFFF, q);
    check_all();
    access(1'b1, 8'h3D, 16'h0000, q);
    check(q, 16'h0000);
    $display("test address decode done");
    do_reset();
    check_all();
    $display("test second reset done");
    give_verdict();
  end

  // cuts a hang short
  initial begin
    #1000000;
    n_errors++;
    give_verdict();
  end
endmodule : sgp_port_test
